// [core/router_reset_defines.svh]
// Purpose: Named constants for the reset-level controller.
// Assumes: Included by bare name from the design files.
// Notes:   Only definitions live here.
`ifndef ROUTER_RESET_DEFINES_SVH
`define ROUTER_RESET_DEFINES_SVH
// Command codes delivered by the control port zero decoder.
`define CMD_CLEAR   2'h0
`define CMD_RECOVER 2'h1
`define CMD_READ    2'h2
`define CMD_WRITE   2'h3
// Reset level parameter values.
`define LVL_ONE     8'h01
`define LVL_TWO     8'h02
// Reply status encoding: true is zero, false is one.
`define STAT_TRUE   1'h0
`define STAT_FALSE  1'h1
// Subsystem addresses in the upper address byte.
`define SUB_LINK0   8'h80
`define SUB_LINK31  8'h9F
`define SUB_ALL     8'hFF
// Local register addresses in the lower address byte.
`define LOC_CMD     8'h02
`define LOC_STATUS  8'h03
// Bit positions inside the port command and status words.
`define BIT_START   0
`define BIT_CLEAR   3
// Time the data side is held in reset after a level command.
`define HOLD_NS     80
`define CLK_NS      8
`endif

// [core/router_reset_level_control.sv]
// Purpose: Reset-level sequencer for a 32-port packet switch.
// Assumes: Commands arrive decoded, one-cycle pulses, on clock.
// Notes:   The device input clock and reset pin are sampled here.
// Contract
// - Pin high one input clock resets everything; code leaves configAbort, ackClear, errorResend, replyStatus and readData out.
// - Command reset spares control links and headers.
// - Resets except level three discard packets.
// - Reset may abort running configuration command.
// - Hardware reset: defaults, idle links, base speed.
// - Hardware reset clears buffers and latched errors.
// - Level one: data links idle, registers default.
// - Level two: registers kept, data links reset.
// - Level three answered false, nothing else.
// - Per-port clear bit holds port until cleared.
// - Valid level completes with true reply, zero.
// - Other levels reply false, one, no action.
// - Cleared handshake state ignores outstanding replies.
// - Recovery clears acknowledges then resends errors.
// - Reads and writes use 16-bit subsystem addresses.
// - Thirty-five subsystems share the configuration bus.
// - Subsystem FF writes all 32 ports together.
`include "router_reset_defines.svh"
module router_reset_level_control #(
  parameter int Ports      = 32,
  parameter int HoldCycles = (`HOLD_NS + `CLK_NS - 1) / `CLK_NS
) (
  input  wire logic                        clock,
  input  wire logic                        rst,
  input  wire logic                        deviceInputClock,
  input  wire logic                        resetPin,
  input  wire logic                        cmdValid,
  input  wire router_reset_pkg::cmd_code_t cmdCode,
  input  wire logic [7:0]                  cmdLevel,
  input  wire logic [15:0]                 cmdAddr,
  input  wire logic [31:0]                 cmdData,
  input  wire logic                        cfgBusy,
  output logic                             chipReset,
  output logic                             controlLinkReset,
  output logic [Ports-1:0]                 dataLinkReset,
  output logic [Ports-1:0]                 portStart,
  output logic                             linkSpeedDefault,
  output logic                             packetDiscard,
  output logic                             configAbort,
  output logic                             configDefaultLoad,
  output logic                             handshakeClear,
  output logic                             errorClear,
  output logic                             ackClear,
  output logic                             errorResend,
  output logic                             replyValid,
  output logic                             replyStatus,
  output logic [31:0]                      readData
);
  // Synchronisers: first stages are read only by second stages.
  logic clkMeta_r, clkSync_r, clkPrev_r, pinMeta_r, pinSync_r;
  logic devEdge;                          // Input clock rising edge.
  logic hwReset_r, hwReset_nxt;           // Hardware reset level.
  router_reset_pkg::state_t state_r, state_nxt;
  logic [7:0]       holdCnt_r, holdCnt_nxt;   // Hold countdown.
  logic             lvlOne_r, lvlOne_nxt;     // Level one in progress.
  logic [Ports-1:0] portClear_r, portClear_nxt; // Per-port clear bits.
  // Registered outputs and their next values.
  logic             chip_r, chip_nxt, ctl_r, ctl_nxt;
  logic [Ports-1:0] dlr_r, dlr_nxt, start_r, start_nxt;
  logic             spd_r, spd_nxt, disc_r, disc_nxt, abt_r, abt_nxt;
  logic             dflt_r, dflt_nxt, hsc_r, hsc_nxt, erc_r, erc_nxt;
  logic             ack_r, ack_nxt, rsd_r, rsd_nxt;
  logic             rv_r, rv_nxt, rs_r, rs_nxt;
  logic [31:0]      rd_r, rd_nxt;
  logic             resetCmd, levelOk;

  // Port index of a link subsystem; valid only inside the link range.
  function automatic logic [4:0] portOf(input logic [7:0] sub);
    portOf = sub[4:0];
  endfunction

  // True when the subsystem byte names a single data port.
  function automatic logic isPort(input logic [7:0] sub);
    isPort = (sub >= `SUB_LINK0) && (sub <= `SUB_LINK31);
  endfunction

  // The input clock is a pin, so it is synchronised before any
  // edge detection; this costs two cycles of latency on the pin.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      clkMeta_r <= 1'h0;
      clkSync_r <= 1'h0;
      clkPrev_r <= 1'h0;
      pinMeta_r <= 1'h0;
      pinSync_r <= 1'h0;
    end else begin
      clkMeta_r <= deviceInputClock;
      clkSync_r <= clkMeta_r;
      clkPrev_r <= clkSync_r;
      pinMeta_r <= resetPin;
      pinSync_r <= pinMeta_r;
    end
  end

  assign devEdge  = clkSync_r & ~clkPrev_r;
  // Reset commands are ignored, with no reply, while the pin reset is active.
  assign resetCmd = cmdValid && (cmdCode == `CMD_CLEAR) && !hwReset_r
                    && (state_r == router_reset_pkg::ST_IDLE);
  assign levelOk  = (cmdLevel == `LVL_ONE) || (cmdLevel == `LVL_TWO);

  // Next-state logic for the sequencer and every output.
  always_comb begin
    // The pin is looked at only on input clock edges.
    hwReset_nxt   = devEdge ? pinSync_r : hwReset_r;
    state_nxt     = state_r;
    holdCnt_nxt   = holdCnt_r;
    lvlOne_nxt    = lvlOne_r;
    portClear_nxt = portClear_r;
    start_nxt     = '0;
    abt_nxt       = 1'h0;
    dflt_nxt      = 1'h0;
    hsc_nxt       = 1'h0;
    erc_nxt       = 1'h0;
    ack_nxt       = 1'h0;
    rsd_nxt       = 1'h0;
    rv_nxt        = 1'h0;
    rs_nxt        = `STAT_TRUE;
    rd_nxt        = rd_r;
    case (state_r)
      router_reset_pkg::ST_IDLE: begin
        if (resetCmd && levelOk) begin
          // Valid level: hold the data side, abort a busy command.
          state_nxt   = router_reset_pkg::ST_CLEAR;
          holdCnt_nxt = 8'(HoldCycles - 1);
          lvlOne_nxt  = (cmdLevel == `LVL_ONE);
          abt_nxt     = cfgBusy;
          hsc_nxt     = 1'h1;
          erc_nxt     = 1'h1;
          if (cmdLevel == `LVL_ONE) begin
            // Registers go back to their power-on values.
            dflt_nxt      = 1'h1;
            portClear_nxt = '0;
          end
        end else if (resetCmd) begin
          // Level three or any other value: refuse with false.
          rv_nxt = 1'h1;
          rs_nxt = `STAT_FALSE;
        end else if (cmdValid && (cmdCode == `CMD_RECOVER)) begin
          // Acknowledge state goes first; errors resend next cycle.
          ack_nxt   = 1'h1;
          state_nxt = router_reset_pkg::ST_RESEND;
        end else if (cmdValid && (cmdCode == `CMD_WRITE)) begin
          rv_nxt = 1'h1;
          if (cmdAddr[7:0] == `LOC_CMD) begin
            // Broadcast reaches every port at once.
            if (cmdAddr[15:8] == `SUB_ALL) begin
              portClear_nxt = {Ports{cmdData[`BIT_CLEAR]}};
              start_nxt     = {Ports{cmdData[`BIT_START]}};
            end else if (isPort(cmdAddr[15:8])) begin
              // Only the addressed port changes.
              portClear_nxt[portOf(cmdAddr[15:8])] =
                cmdData[`BIT_CLEAR];
              start_nxt[portOf(cmdAddr[15:8])] =
                cmdData[`BIT_START];
            end
          end
        end else if (cmdValid && (cmdCode == `CMD_READ)) begin
          // Status read shows the port's clear bit; others read 0.
          rv_nxt = 1'h1;
          rd_nxt = '0;
          if (isPort(cmdAddr[15:8]) &&
              (cmdAddr[7:0] == `LOC_STATUS)) begin
            rd_nxt[`BIT_CLEAR] = portClear_r[portOf(cmdAddr[15:8])];
          end
        end
      end
      router_reset_pkg::ST_CLEAR: begin
        // Completion reply goes out once the hold time has run.
        if (holdCnt_r == 8'h00) begin
          state_nxt = router_reset_pkg::ST_IDLE;
          rv_nxt    = 1'h1;
          rs_nxt    = `STAT_TRUE;
        end else begin
          holdCnt_nxt = holdCnt_r - 8'h01;
        end
      end
      router_reset_pkg::ST_RESEND: begin
        rsd_nxt   = 1'h1;
        state_nxt = router_reset_pkg::ST_IDLE;
      end
      default: state_nxt = router_reset_pkg::ST_IDLE;
    endcase
    // Pin reset overrides all outputs but configAbort, ackClear, errorResend, replyStatus and readData, control links included.
    if (hwReset_nxt) begin
      state_nxt     = router_reset_pkg::ST_IDLE;
      portClear_nxt = '0;
      start_nxt     = '0;
      rv_nxt        = 1'h0;
      hsc_nxt       = 1'h1;
      erc_nxt       = 1'h1;
      dflt_nxt      = 1'h1;
    end
    chip_nxt = hwReset_nxt;
    // Command resets never touch the control links.
    ctl_nxt  = hwReset_nxt;
    // Held ports stay in reset whatever else happens.
    dlr_nxt  = portClear_r | {Ports{hwReset_nxt ||
               (state_nxt == router_reset_pkg::ST_CLEAR)}};
    spd_nxt  = hwReset_nxt || ((state_nxt == router_reset_pkg::ST_CLEAR)
               && lvlOne_nxt);
    disc_nxt = hwReset_nxt ||
               (state_nxt == router_reset_pkg::ST_CLEAR);
  end

  // Registers only; power-on leaves the chip held in pin reset.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      hwReset_r   <= 1'h1;
      state_r     <= router_reset_pkg::ST_IDLE;
      holdCnt_r   <= 8'h00;
      lvlOne_r    <= 1'h0;
      portClear_r <= '0;
      chip_r      <= 1'h1;
      ctl_r       <= 1'h1;
      dlr_r       <= '1;
      start_r     <= '0;
      spd_r       <= 1'h1;
      disc_r      <= 1'h1;
      abt_r       <= 1'h0;
      dflt_r      <= 1'h1;
      hsc_r       <= 1'h1;
      erc_r       <= 1'h1;
      ack_r       <= 1'h0;
      rsd_r       <= 1'h0;
      rv_r        <= 1'h0;
      rs_r        <= 1'h0;
      rd_r        <= 32'h0000_0000;
    end else begin
      hwReset_r   <= hwReset_nxt;
      state_r     <= state_nxt;
      holdCnt_r   <= holdCnt_nxt;
      lvlOne_r    <= lvlOne_nxt;
      portClear_r <= portClear_nxt;
      chip_r      <= chip_nxt;
      ctl_r       <= ctl_nxt;
      dlr_r       <= dlr_nxt;
      start_r     <= start_nxt;
      spd_r       <= spd_nxt;
      disc_r      <= disc_nxt;
      abt_r       <= abt_nxt;
      dflt_r      <= dflt_nxt;
      hsc_r       <= hsc_nxt;
      erc_r       <= erc_nxt;
      ack_r       <= ack_nxt;
      rsd_r       <= rsd_nxt;
      rv_r        <= rv_nxt;
      rs_r        <= rs_nxt;
      rd_r        <= rd_nxt;
    end
  end

  // Outputs come straight from the flops above.
  assign chipReset         = chip_r;
  assign controlLinkReset  = ctl_r;
  assign dataLinkReset     = dlr_r;
  assign portStart         = start_r;
  assign linkSpeedDefault  = spd_r;
  assign packetDiscard     = disc_r;
  assign configAbort       = abt_r;
  assign configDefaultLoad = dflt_r;
  assign handshakeClear    = hsc_r;
  assign errorClear        = erc_r;
  assign ackClear          = ack_r;
  assign errorResend       = rsd_r;
  assign replyValid        = rv_r;
  assign replyStatus       = rs_r;
  assign readData          = rd_r;

  // Checks on the sequencer, kept beside the logic they guard.
  a_pin_chip_reset: assert property (@(posedge clock) disable iff (rst)
    devEdge && pinSync_r |=> chipReset && controlLinkReset)
    else $error("Pin reset did not reset the chip.");
  a_ctl_link_kept: assert property (@(posedge clock) disable iff (rst)
    resetCmd && !hwReset_nxt |=> !controlLinkReset)
    else $error("Command reset touched the control links.");
  a_discard_valid: assert property (@(posedge clock) disable iff (rst)
    resetCmd && levelOk && !hwReset_nxt |=> packetDiscard[*2])
    else $error("Valid reset did not discard packets.");
  a_abort_busy: assert property (@(posedge clock) disable iff (rst)
    resetCmd && levelOk && cfgBusy |=> configAbort)
    else $error("Busy configuration command not aborted.");
  a_hw_state: assert property (@(posedge clock) disable iff (rst)
    hwReset_r |-> state_r == router_reset_pkg::ST_IDLE
      && portClear_r == '0 && linkSpeedDefault && errorClear)
    else $error("Pin reset state not at defaults.");
  a_level_one: assert property (@(posedge clock) disable iff (rst)
    resetCmd && cmdLevel == `LVL_ONE && !hwReset_nxt
      |=> configDefaultLoad && linkSpeedDefault && dataLinkReset == '1)
    else $error("Level one reset incomplete.");
  a_level_two: assert property (@(posedge clock) disable iff (rst)
    resetCmd && cmdLevel == `LVL_TWO && !hwReset_nxt
      |=> !configDefaultLoad && $stable(portClear_r) && !linkSpeedDefault)
    else $error("Level two reset disturbed registers.");
  a_bad_level: assert property (@(posedge clock) disable iff (rst)
    resetCmd && !levelOk && !hwReset_nxt
      |=> replyValid && replyStatus && !packetDiscard)
    else $error("Invalid level not refused cleanly.");
  // A pin reset during the hold legally cancels the reply.
  a_good_reply: assert property (@(posedge clock)
    disable iff (rst || hwReset_nxt)
    resetCmd && levelOk && !hwReset_nxt
      |-> ##[1:300] (replyValid && !replyStatus))
    else $error("Valid reset never answered true.");
  a_port_hold: assert property (@(posedge clock) disable iff (rst)
    portClear_r[0] |=> dataLinkReset[0])
    else $error("Cleared port left running.");
  a_recover_order: assert property (@(posedge clock) disable iff (rst)
    $rose(ackClear) && !hwReset_nxt |-> !errorResend ##1 errorResend)
    else $error("Recovery steps out of order.");
endmodule

// [core/router_reset_pkg.sv]
// Purpose: Types shared by the reset-level controller.
// Assumes: Nothing beyond the constants header.
// Notes:   State names carry no explicit codes; they take 0, 1 and 2 in order.
package router_reset_pkg;
  // Sequencer states.
  typedef enum logic [1:0] {ST_IDLE, ST_CLEAR, ST_RESEND} state_t;
  // Command code carried on the command port.
  typedef logic [1:0] cmd_code_t;
endpackage

// [test/ctrl_link_model.sv]
// Purpose: Far-side controller model: device input clock and reset pin.
// Assumes: The device input clock runs free, as a board clock does.
// Notes:   The pin only moves on falling clock edges, so each rising
//          edge sees a settled level.
module ctrl_link_model (
  input  wire logic pinReq,
  output logic      deviceInputClock,
  output logic      resetPin
);
  timeunit 1ns;
  timeprecision 100ps;

  // A 125 ns clock, offset so it never lines up with the system clock.
  initial begin
    deviceInputClock = 1'h0;
    #3.3;
    forever #62.5 deviceInputClock = ~deviceInputClock;
  end

  // The pin follows the request across at least one rising edge.
  // One process drives the pin, so it starts low and then tracks.
  initial begin
    resetPin = 1'h0;
    forever @(negedge deviceInputClock) resetPin <= pinReq;
  end
endmodule

// [test/tb_top.sv]
// Purpose: Self-checking bench for the reset-level sequencer.
// Assumes: Commands spaced by the replies, as the hand-over asks.
// Notes:   A short hold keeps level commands quick to run.
`include "router_reset_defines.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int HOLD = 2; // Short hold; expectations follow it.

  logic        clock, rst, devClk, resetPin, pinReq;
  logic        cmdValid, cfgBusy;
  router_reset_pkg::cmd_code_t cmdCode;
  logic [7:0]  cmdLevel;
  logic [15:0] cmdAddr;
  logic [31:0] cmdData, dataLinkReset, portStart, readData;
  logic        chipReset, controlLinkReset, linkSpeedDefault;
  logic        packetDiscard, configAbort, configDefaultLoad;
  logic        handshakeClear, errorClear, ackClear, errorResend;
  logic        replyValid, replyStatus;
  int          err_total, num_checks;
  // Snapshot taken the cycle after a command is taken.
  logic        pd1, ld1, cd1, ca1, hc1, ec1, cr1;
  logic [31:0] dl1, stSeen;
  int          repK, ackK, resK;
  logic        repSt;

  ctrl_link_model part_u (
    .pinReq           (pinReq),
    .deviceInputClock (devClk),
    .resetPin         (resetPin)
  );

  router_reset_level_control #(.Ports(32), .HoldCycles(HOLD)) dut_u (
    .clock (clock), .rst (rst), .deviceInputClock (devClk),
    .resetPin (resetPin), .cmdValid (cmdValid), .cmdCode (cmdCode),
    .cmdLevel (cmdLevel), .cmdAddr (cmdAddr), .cmdData (cmdData),
    .cfgBusy (cfgBusy), .chipReset (chipReset),
    .controlLinkReset (controlLinkReset),
    .dataLinkReset (dataLinkReset), .portStart (portStart),
    .linkSpeedDefault (linkSpeedDefault),
    .packetDiscard (packetDiscard), .configAbort (configAbort),
    .configDefaultLoad (configDefaultLoad),
    .handshakeClear (handshakeClear), .errorClear (errorClear),
    .ackClear (ackClear), .errorResend (errorResend),
    .replyValid (replyValid), .replyStatus (replyStatus),
    .readData (readData)
  );

  // The 125 MHz system clock.
  initial clock = 1'h0;
  always #4 clock = ~clock;

  // Compares one value and counts it; a mismatch is printed at once.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic end_of_test;
    $display("Checks %0d, mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Issues one command pulse, then watches eight cycles of answers.
  // Eight cycles outlast every reply, so the next command is legal.
  task automatic cmd(input router_reset_pkg::cmd_code_t c,
                     input logic [7:0] lv, input logic [15:0] a,
                     input logic [31:0] d);
    @(posedge clock);
    #1;
    cmdValid = 1'h1;
    cmdCode  = c;
    cmdLevel = lv;
    cmdAddr  = a;
    cmdData  = d;
    @(posedge clock);
    #1;
    cmdValid = 1'h0;
    repK = 0;
    ackK = 0;
    resK = 0;
    stSeen = 32'h0;
    for (int k = 1; k <= 8; k++) begin
      if (k == 1) begin
        {pd1, ld1, cd1, ca1} = {packetDiscard, linkSpeedDefault,
                                configDefaultLoad, configAbort};
        {hc1, ec1, cr1, dl1} = {handshakeClear, errorClear,
                                chipReset | controlLinkReset,
                                dataLinkReset};
      end
      if (replyValid === 1'h1 && repK == 0) begin
        repK  = k;
        repSt = replyStatus;
      end
      if (ackClear === 1'h1) ackK = k;
      if (errorResend === 1'h1) resK = k;
      stSeen |= portStart;
      @(posedge clock);
      #1;
    end
  endtask

  // Waits, bounded, for the whole-chip reset to reach a level.
  task automatic waitChip(input logic v);
    int n;
    n = 0;
    while (chipReset !== v && n < 300) begin
      @(posedge clock);
      #1;
      n++;
    end
    chk(chipReset, v);
  endtask

  // Cuts a hang short; the tests need well under 20 microseconds.
  initial begin
    #200000;
    err_total++;
    end_of_test();
  end

  // Main sequence.
  initial begin
    {rst, pinReq, cmdValid, cfgBusy} = 4'h8;
    {cmdCode, cmdLevel, cmdAddr, cmdData} = '0;
    err_total = 0;
    num_checks = 0;
    repeat (3) @(posedge clock);
    #1;
    rst = 1'h0;
    chk(dataLinkReset, 32'hFFFFFFFF);
    chk(linkSpeedDefault, 1'h1);
    chk(errorClear, 1'h1);
    waitChip(1'h0);
    chk(dataLinkReset, 32'h0);
    // Clear bit on port 5, then read it back from the status word.
    cmd(`CMD_WRITE, 8'h00, 16'h8502, 32'h8);
    chk(repK, 1);
    chk(dataLinkReset, 32'h20);
    cmd(`CMD_READ, 8'h00, 16'h8503, 32'h0);
    chk(readData[3], 1'h1);
    // Level two while a configuration command is running.
    cfgBusy = 1'h1;
    cmd(`CMD_CLEAR, `LVL_TWO, 16'h0, 32'h0);
    cfgBusy = 1'h0;
    chk({pd1, ca1, hc1, ec1}, 4'hF);
    chk({cr1, cd1, ld1}, 3'h0);
    chk(dl1, 32'hFFFFFFFF);
    chk({repK[7:0], repSt}, {8'(HOLD + 1), 1'h0});
    chk(dataLinkReset, 32'h20);
    // Level one reloads defaults, so the clear bit goes.
    cmd(`CMD_CLEAR, `LVL_ONE, 16'h0, 32'h0);
    chk({pd1, ld1, cd1, ca1, cr1}, 5'h1C);
    chk({repK[7:0], repSt}, {8'(HOLD + 1), 1'h0});
    chk(dataLinkReset, 32'h0);
    // Every level other than one and two is refused and does nothing.
    // Level three comes first; zero, four and all ones follow it.
    for (int i = 0; i < 4; i++) begin
      cmd(`CMD_CLEAR, 8'(i == 0 ? 3 : i == 1 ? 0 : i == 2 ? 4 : 255),
          16'h0, 32'h0);
      chk({repK[7:0], repSt}, {8'h01, 1'h1});
      chk({pd1, hc1}, 2'h0);
      chk(dl1, 32'h0);
    end
    // Whole partition into clear before any port leaves it.
    cmd(`CMD_WRITE, 8'h00, 16'hFF02, 32'h8);
    chk(dataLinkReset, 32'hFFFFFFFF);
    cmd(`CMD_WRITE, 8'h00, 16'hFF02, 32'h0);
    chk(dataLinkReset, 32'h0);
    cmd(`CMD_WRITE, 8'h00, 16'h8702, 32'h1);
    chk(stSeen, 32'h80);
    // Recovery: acknowledge state first, resend next, no reply.
    cmd(`CMD_RECOVER, 8'h00, 16'h0, 32'h0);
    chk({ackK[7:0], resK[7:0], repK[7:0]}, {8'h01, 8'h02, 8'h00});
    // Pin reset resets links, buffers and errors, even the per-port clear bits.
    cmd(`CMD_WRITE, 8'h00, 16'h8902, 32'h8);
    pinReq = 1'h1;
    waitChip(1'h1);
    chk({controlLinkReset, packetDiscard, errorClear}, 3'h7);
    chk(dataLinkReset, 32'hFFFFFFFF);
    repeat (40) @(posedge clock);
    #1;
    chk(chipReset, 1'h1);
    pinReq = 1'h0;
    waitChip(1'h0);
    chk(dataLinkReset, 32'h0);
    end_of_test();
  end
endmodule
